// File: hdl/ccl_pkg.sv
/*
  Package for the counter command-list engine: word layouts, opcodes,
  sizes, reset values and the shared carrier structs.
  Assumes a single clock domain and a host that fills the memory.
*/
package ccl_pkg;

  localparam int CCL_DATA_W    = 32;
  localparam int CCL_WORD_W    = 16;
  localparam int CCL_ADDR_W    = 8;
  localparam int CCL_NUM_CNT   = 5;
  localparam int CCL_NUM_CONST = 16;
  localparam int CCL_NUM_RES   = 8;
  localparam int CCL_NUM_LIST  = 7;
  localparam int CCL_NUM_FREF  = 6;

  // Word layout
  localparam int CCL_OP_HI  = 15;
  localparam int CCL_OP_LO  = 8;
  localparam int CCL_SRC_HI = 7;
  localparam int CCL_SRC_LO = 4;
  localparam int CCL_IDX_HI = 3;
  localparam int CCL_IDX_LO = 0;

  // Opcode bytes
  localparam logic [7:0] CCL_OP_END   = 8'h00;
  localparam logic [7:0] CCL_OP_SAVE  = 8'h16;
  localparam logic [7:0] CCL_OP_RELD  = 8'h37;
  localparam logic [7:0] CCL_OP_CALL  = 8'h82;
  localparam logic [7:0] CCL_OP_LOAD  = 8'h90;
  localparam logic [7:0] CCL_OP_XFER  = 8'h91;
  localparam logic [7:0] CCL_OP_MUL   = 8'h95;
  localparam logic [7:0] CCL_OP_DIV   = 8'h96;

  // Operand source field
  localparam logic [3:0] CCL_SRC_NONE  = 4'h0;
  localparam logic [3:0] CCL_SRC_HOLD  = 4'h2;
  localparam logic [3:0] CCL_SRC_RES   = 4'h4;
  localparam logic [3:0] CCL_SRC_CONST = 4'h5;

  localparam logic [CCL_DATA_W-1:0] CCL_ACC_RST = 32'h0000_0000;
  localparam logic [CCL_WORD_W-1:0] CCL_END_WORD = 16'h0000;
  localparam int CCL_DIV_CYC = CCL_DATA_W;

  typedef struct packed {
    logic [CCL_DATA_W-1:0] acc1;
    logic [CCL_DATA_W-1:0] acc2;
  } ccl_accu_t;

  typedef struct packed {
    logic [CCL_NUM_CNT-1:0] save;
    logic [CCL_NUM_CNT-1:0] reload;
  } ccl_cnt_cmd_t;

endpackage

// File: hdl/ccl_divider.sv
/*
  Sequential restoring divider, one quotient bit per enabled cycle.
  Assumes nothing of the operands after start: both are captured then.
*/
`timescale 1ns/1ps
module ccl_divider
  import ccl_pkg::*;
#(
  parameter int W = CCL_DATA_W
)
(
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         en,
  input  wire logic         start,
  input  wire logic [W-1:0] dividend,
  input  wire logic [W-1:0] divisor,
  output logic              busy,
  output logic              done,
  output logic [W-1:0]      quotient
);

  logic [W-1:0]         remQ;
  logic [W-1:0]         dvsQ;
  logic [$clog2(W):0]   cntQ;
  logic [W:0]           trial;

  assign trial = {remQ, quotient[W-1]} - {1'b0, dvsQ};

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      remQ     <= '0;
      dvsQ     <= '0;
      quotient <= '0;
      cntQ     <= '0;
      busy     <= 1'b0;
      done     <= 1'b0;
    end
    else if (en)
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        remQ     <= '0;
        dvsQ     <= divisor;
        quotient <= dividend;
        cntQ     <= ($clog2(W)+1)'(W);
        busy     <= 1'b1;
      end
      else if (busy)
      begin
        // Division by zero yields all ones: every trial subtract succeeds
        if (!trial[W])
          remQ <= trial[W-1:0];
        else
          remQ <= {remQ[W-2:0], quotient[W-1]};
        quotient <= {quotient[W-2:0], ~trial[W]};
        cntQ     <= cntQ - 1'b1;
        if (cntQ == 1)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule

// File: hdl/ccl_engine.sv
/*
  Command-list engine: runs the gate interrupt list of a counter and the
  additional lists it calls, with a two-entry accumulator stack.
  Assumes the host fills list memory, directory and constants through the
  write port before the gate event, and reads results on the read port.
*/
`timescale 1ns/1ps
// Function
// [RULE1] Host writes list start into directory
// [RULE2] List length from next directory entry
// [RULE3] Additional list ends by length; interrupt by zero
// [RULE4] Call word runs one-hot selected list
// [RULE5] Save copies selected counts to hold
// [RULE6] Reload counter from load register, keep running
// [RULE7] Gate list runs on inactive gate edge
// [RULE8] Load constant register into accumulator
// [RULE9] Load hold register into accumulator
// [RULE10] Load result register into accumulator
// [RULE11] Plain divide: accu2 by accu1
// [RULE12] Multiply with implicit operand load
// [RULE13] Divide with implicit operand load
// [RULE14] Transfer accumulator to result register
// [RULE15] Results stay readable after completion
// [RULE16] Reference frequency selectable as count input
// [RULE17] Host programs overspeed output disable; the engine has no overspeed output
// [RULE18] Explicit load pushes accu1 into accu2
module ccl_engine
  import ccl_pkg::*;
#(
  parameter int NCNT = CCL_NUM_CNT,
  parameter int AW   = CCL_ADDR_W
)
(
  input  wire logic                         clk,
  input  wire logic                         arst_n,
  input  wire logic                         clkEn,
  input  wire logic                         hostWrEn,
  input  wire logic [1:0]                   hostWrSel,
  input  wire logic [AW-1:0]                hostWrAddr,
  input  wire logic [ccl_pkg::CCL_DATA_W-1:0] hostWrData,
  input  wire logic [2:0]                   hostRdSel,
  output logic [ccl_pkg::CCL_DATA_W-1:0]    hostRdData,
  input  wire logic [AW-1:0]                gateListStart,
  input  wire logic                         gateActiveHigh,
  input  wire logic                         gatePin,
  input  wire logic [NCNT-1:0][ccl_pkg::CCL_DATA_W-1:0] countValue,
  input  wire logic [ccl_pkg::CCL_NUM_FREF-1:0] refFreq,
  input  wire logic [2:0]                   refFreqSel,
  output logic                              refCountPulse,
  output ccl_pkg::ccl_cnt_cmd_t             cntCmd,
  output logic [NCNT-1:0][ccl_pkg::CCL_DATA_W-1:0] holdReg,
  output logic                              busy
);
  import ccl_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_FETCH = 3'b001,
    S_EXEC  = 3'b011,
    S_DIVW  = 3'b010,
    S_RET   = 3'b110
  } ccl_state_t;

  localparam logic [1:0] WSEL_LIST  = 2'd0;
  localparam logic [1:0] WSEL_DIR   = 2'd1;
  localparam logic [1:0] WSEL_CONST = 2'd2;

  logic [CCL_WORD_W-1:0] listMem [2**AW];
  logic [AW-1:0]         dirMem  [CCL_NUM_LIST+1];
  logic [CCL_DATA_W-1:0] constReg [CCL_NUM_CONST];
  logic [CCL_DATA_W-1:0] resultReg [CCL_NUM_RES];

  ccl_state_t            stateQ;
  ccl_state_t            stateD;
  ccl_accu_t             accQ;
  logic [AW-1:0]         pcQ;
  logic [AW-1:0]         retPcQ;
  logic [AW-1:0]         remainQ;
  logic                  inSubQ;
  logic [CCL_WORD_W-1:0] wordQ;
  logic [1:0]            gateSyncQ;
  logic                  gateLastQ;
  logic                  gateEvent;
  logic [7:0]            opByte;
  logic [3:0]            srcF;
  logic [3:0]            idxF;
  logic [CCL_DATA_W-1:0] operand;
  logic [CCL_DATA_W-1:0] divDividend;
  logic [CCL_DATA_W-1:0] divDivisor;
  logic [CCL_DATA_W-1:0] quotient;
  logic                  divStart;
  logic                  divBusy;
  logic                  divDone;
  logic [2:0]            callIdx;
  logic                  listDone;
  logic [2*CCL_DATA_W-1:0] product;

  // One-hot low byte to list number; bit 0 unused, bit n selects list n
  function automatic logic [2:0] onehot_index(input logic [7:0] sel);
    logic [2:0] idx;
    idx = 3'd0;
    for (int i = 1; i < 8; i++)
      if (sel[i])
        idx = 3'(i);
    return idx;
  endfunction

  function automatic logic [CCL_DATA_W-1:0] fetch_operand(
    input logic [3:0] src,
    input logic [3:0] idx);
    logic [CCL_DATA_W-1:0] v;
    v = '0;
    case (src)
      CCL_SRC_HOLD:
        if (idx >= 1 && idx <= 4'(NCNT))
          v = holdReg[idx-1'b1];
      CCL_SRC_RES:
        v = resultReg[idx[2:0]];
      CCL_SRC_CONST:
        v = constReg[idx];
      default:
        v = '0;
    endcase
    return v;
  endfunction

  assign opByte = wordQ[CCL_OP_HI:CCL_OP_LO];
  assign srcF   = wordQ[CCL_SRC_HI:CCL_SRC_LO];
  assign idxF   = wordQ[CCL_IDX_HI:CCL_IDX_LO];
  assign operand = fetch_operand(srcF, idxF);
  assign product = accQ.acc1 * operand;
  assign callIdx = onehot_index(wordQ[7:0]);
  assign busy    = (stateQ != S_IDLE);

  // Host write port into list memory, directory and constants
  always_ff @(posedge clk)
  begin
    if (clkEn && hostWrEn)
    begin
      case (hostWrSel)
        WSEL_LIST:  listMem[hostWrAddr] <= hostWrData[CCL_WORD_W-1:0];
        WSEL_DIR:   dirMem[hostWrAddr[2:0]] <= hostWrData[AW-1:0]; // RULE1
        WSEL_CONST: constReg[hostWrAddr[3:0]] <= hostWrData;
        default:    ;
      endcase
    end
  end

  // Gate pin synchroniser and inactive-edge detect
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gateSyncQ <= 2'b00;
      gateLastQ <= 1'b0;
    end
    else if (clkEn)
    begin
      gateSyncQ <= {gateSyncQ[0], gatePin};
      gateLastQ <= gateSyncQ[1];
    end
  end

  // A gate ending while a list is running is dropped, not queued
  assign gateEvent = gateActiveHigh ? (gateLastQ && !gateSyncQ[1])
                                    : (!gateLastQ && gateSyncQ[1]); // RULE7

  // Reference frequency mux onto the counting input
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      refCountPulse <= 1'b0;
    else if (clkEn)
    begin
      if (refFreqSel >= 3'd1 && refFreqSel <= 3'(CCL_NUM_FREF))
        refCountPulse <= refFreq[refFreqSel-1'b1]; // RULE16
      else
        refCountPulse <= 1'b0;
    end
  end

  assign listDone = inSubQ ? (remainQ == '0)
                           : 1'b0;

  always_comb
  begin
    stateD = stateQ;
    case (stateQ)
      S_IDLE:  if (gateEvent) stateD = S_FETCH;
      S_FETCH: stateD = listDone ? S_RET : S_EXEC;
      S_EXEC:
        if (!inSubQ && wordQ == CCL_END_WORD)
          stateD = S_IDLE; // RULE3
        else if (opByte == CCL_OP_DIV)
          stateD = S_DIVW;
        else
          stateD = S_FETCH;
      S_DIVW:  if (divDone) stateD = S_FETCH;
      S_RET:   stateD = S_FETCH;
      default: stateD = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      stateQ <= S_IDLE;
    else if (clkEn)
      stateQ <= stateD;
  end

  // Sequencing: program counter, call/return and additional list length
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pcQ     <= '0;
      retPcQ  <= '0;
      remainQ <= '0;
      inSubQ  <= 1'b0;
      wordQ   <= '0;
    end
    else if (clkEn)
    begin
      case (stateQ)
        S_IDLE:
          if (gateEvent)
          begin
            pcQ    <= gateListStart;
            inSubQ <= 1'b0;
          end
        S_FETCH:
          if (!listDone)
          begin
            wordQ <= listMem[pcQ];
            pcQ   <= pcQ + 1'b1;
            if (inSubQ)
              remainQ <= remainQ - 1'b1; // RULE3
          end
        S_EXEC:
          if (!inSubQ && opByte == CCL_OP_CALL && callIdx != 3'd0)
          begin
            retPcQ  <= pcQ; // RULE4
            pcQ     <= dirMem[callIdx - 1'b1];
            remainQ <= dirMem[callIdx] - dirMem[callIdx - 1'b1]; // RULE2
            inSubQ  <= 1'b1;
          end
        S_RET:
        begin
          pcQ    <= retPcQ; // RULE4
          inSubQ <= 1'b0;
        end
        default: ;
      endcase
    end
  end

  // Counter commands are one-cycle pulses per selected counter
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cntCmd <= '0;
    else if (clkEn)
    begin
      cntCmd <= '0;
      if (stateQ == S_EXEC)
      begin
        if (opByte == CCL_OP_SAVE)
          cntCmd.save <= wordQ[NCNT:1];
        if (opByte == CCL_OP_RELD)
          cntCmd.reload <= wordQ[NCNT:1]; // RULE6
      end
    end
  end

  for (genvar c = 0; c < NCNT; c++)
  begin : g_hold
    always_ff @(posedge clk or negedge arst_n)
    begin
      if (!arst_n)
        holdReg[c] <= '0;
      else if (clkEn && stateQ == S_EXEC && opByte == CCL_OP_SAVE
               && wordQ[c+1])
        holdReg[c] <= countValue[c]; // RULE5
    end
  end

  // Divide operands: implicit form divides accu1 by new operand
  assign divStart    = (stateQ == S_EXEC) && (opByte == CCL_OP_DIV);
  assign divDividend = (srcF == CCL_SRC_NONE) ? accQ.acc2 : accQ.acc1;
  assign divDivisor  = (srcF == CCL_SRC_NONE) ? accQ.acc1 : operand;

  ccl_divider #(
    .W (CCL_DATA_W)
  ) u_div (
    .clk      (clk),
    .arst_n   (arst_n),
    .en       (clkEn),
    .start    (divStart),
    .dividend (divDividend), // RULE11 RULE13
    .divisor  (divDivisor),
    .busy     (divBusy),
    .done     (divDone),
    .quotient (quotient)
  );

  // Accumulator pair
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      accQ <= {CCL_ACC_RST, CCL_ACC_RST};
    else if (clkEn)
    begin
      if (stateQ == S_EXEC && opByte == CCL_OP_LOAD)
      begin
        accQ.acc2 <= accQ.acc1; // RULE18
        accQ.acc1 <= operand; // RULE8 RULE9 RULE10
      end
      else if (stateQ == S_EXEC && opByte == CCL_OP_MUL)
      begin
        // Product keeps the low word; overflow is not flagged
        accQ.acc2 <= accQ.acc1;
        accQ.acc1 <= (srcF == CCL_SRC_NONE)
                     ? CCL_DATA_W'(accQ.acc1 * accQ.acc2)
                     : product[CCL_DATA_W-1:0]; // RULE12
      end
      else if (stateQ == S_DIVW && divDone)
        accQ.acc1 <= quotient; // RULE11 RULE13
    end
  end

  // Result registers, written by transfer, read by host at any time
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int r = 0; r < CCL_NUM_RES; r++)
        resultReg[r] <= '0;
    end
    else if (clkEn && stateQ == S_EXEC && opByte == CCL_OP_XFER
             && srcF == CCL_SRC_RES)
      resultReg[idxF[2:0]] <= accQ.acc1; // RULE14
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      hostRdData <= '0;
    else if (clkEn)
      hostRdData <= resultReg[hostRdSel]; // RULE15
  end

endmodule

// File: dv/ccl_engine_checker.sv
/*
  Port checker for the command-list engine.
  Assumes it is bound to ccl_engine and shares its single clock.
*/
`timescale 1ns/1ps
module ccl_engine_checker
  import ccl_pkg::*;
#(
  parameter int NCNT = CCL_NUM_CNT,
  parameter int AW   = CCL_ADDR_W
)
(
  input wire logic                          clk,
  input wire logic                          arst_n,
  input wire logic                          clkEn,
  input wire logic                          gateActiveHigh,
  input wire logic                          gatePin,
  input wire logic [NCNT-1:0][CCL_DATA_W-1:0] countValue,
  input wire logic [CCL_NUM_FREF-1:0]       refFreq,
  input wire logic [2:0]                    refFreqSel,
  input wire logic                          refCountPulse,
  input wire ccl_pkg::ccl_cnt_cmd_t         cntCmd,
  input wire logic [NCNT-1:0][CCL_DATA_W-1:0] holdReg,
  input wire logic                          busy
);
  import ccl_pkg::*;
  logic refSel;

  always_comb
  begin
    refSel = 1'b0;
    if (refFreqSel >= 3'h1 && refFreqSel <= 3'h6)
      refSel = refFreq[refFreqSel - 3'h1];
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  chk_save_hold: assert property (
    (cntCmd.save[0] && $stable(countValue[0]))
      |-> ##[0:1] (holdReg[0] == countValue[0]))
    else $error("hold register 1 missed the saved count");
  chk_pulse_once: assert property (
    (clkEn && cntCmd != '0) |=> (cntCmd == '0))
    else $error("counter command pulse longer than one cycle");
  chk_cmd_busy: assert property (
    (cntCmd != '0) |-> busy)
    else $error("counter command outside a running list");
  chk_ref_select: assert property (
    clkEn |=> (refCountPulse == $past(refSel)))
    else $error("reference pulse not the selected source");
  chk_gate_start: assert property (
    (gateActiveHigh && clkEn && !busy && $fell(gatePin))
      |-> ##[1:4] busy)
    else $error("inactive gate edge did not start the list");
  chk_active_quiet: assert property (
    (gateActiveHigh && !busy && $rose(gatePin) && !$past(gatePin, 2)
      && !$past(gatePin, 3) && !$past(gatePin, 4)) |=> !busy [*4])
    else $error("active gate edge started a list");
  chk_hold_cause: assert property (
    $changed(holdReg) |-> (cntCmd.save != '0 || $past(cntCmd.save) != '0))
    else $error("hold register changed without a save");
  chk_busy_cause: assert property (
    $rose(busy) |-> ($past(gatePin, 2) != gateActiveHigh))
    else $error("list started without an inactive gate level");

  cp_save: cover property (cntCmd.save[0]);
  cp_reload: cover property (cntCmd.reload[1]);
  cp_run: cover property ($fell(busy));
endmodule

bind ccl_engine ccl_engine_checker #(
  .NCNT(NCNT),
  .AW  (AW)
) i_ccl_engine_checker (
  .clk           (clk),
  .arst_n        (arst_n),
  .clkEn         (clkEn),
  .gateActiveHigh(gateActiveHigh),
  .gatePin       (gatePin),
  .countValue    (countValue),
  .refFreq       (refFreq),
  .refFreqSel    (refFreqSel),
  .refCountPulse (refCountPulse),
  .cntCmd        (cntCmd),
  .holdReg       (holdReg),
  .busy          (busy)
);

// File: dv/ccl_host_model.sv
/*
  Host controller model: fills list memory, directory and constants
  and reads result registers. Assumes the engine's one-cycle read port.
*/
`timescale 1ns/1ps
module ccl_host_model
  import ccl_pkg::*;
#(
  parameter int AW = CCL_ADDR_W
)
(
  input  wire logic                          clk,
  output logic                               hostWrEn,
  output logic [1:0]                         hostWrSel,
  output logic [AW-1:0]                      hostWrAddr,
  output logic [ccl_pkg::CCL_DATA_W-1:0]     hostWrData,
  output logic [2:0]                         hostRdSel,
  input  wire logic [ccl_pkg::CCL_DATA_W-1:0] hostRdData
);
  import ccl_pkg::*;

  initial
  begin
    hostWrEn = 1'b0;
    hostWrSel = 2'h3;
    hostWrAddr = '0;
    hostWrData = 32'hA5A5_5A5A;
    hostRdSel = 3'h0;
  end

  // Directory entries go in after the lists that call through them, before any gate run
  task automatic wr(input logic [1:0] sel, input logic [AW-1:0] a,
                    input logic [CCL_DATA_W-1:0] d);
    @(posedge clk);
    hostWrEn <= 1'b1;
    hostWrSel <= sel;
    hostWrAddr <= a;
    hostWrData <= d;
    @(posedge clk);
    hostWrEn <= 1'b0;
    // Released data never keeps the last value
    hostWrData <= ~d;
  endtask

  task automatic rd(input logic [2:0] idx,
                    output logic [CCL_DATA_W-1:0] d);
    @(posedge clk);
    hostRdSel <= idx;
    @(posedge clk);
    @(posedge clk);
    #1 d = hostRdData;
  endtask
endmodule

// File: dv/ccl_engine_tb.sv
/*
  Self-checking bench for the command-list engine.
  Assumes the host model writes memory and reads results for it.
*/
`timescale 1ns/1ps
module ccl_engine_tb;
  import ccl_pkg::*;
  logic                 clk, arst_n, hostWrEn, gateActiveHigh, gatePin;
  logic                 clkEn, sawClr;
  logic [1:0]           hostWrSel;
  logic [7:0]           hostWrAddr, gateListStart;
  logic [31:0]          hostWrData, hostRdData, rv;
  logic [2:0]           hostRdSel, refFreqSel;
  logic [4:0][31:0]     countValue, holdReg;
  logic [5:0]           refFreq;
  logic                 refCountPulse, busy;
  ccl_cnt_cmd_t         cntCmd;
  logic [4:0]           sawSave, sawReload;
  int                   fail_count, compares;
  logic [25:0]          prog [34] = '{
    26'h0001602, 26'h0013702, 26'h0028202, 26'h0030000,
    26'h0081604, 26'h0093704, 26'h00A8208, 26'h00B0000,
    26'h0108201, 26'h0118204, 26'h0120000,
    26'h0289050, 26'h0299021, 26'h02A9600, 26'h02B9141,
    26'h02C9041, 26'h02D9142, 26'h02E9041, 26'h02F9522,
    26'h0309551, 26'h0319652, 26'h0329143, 26'h0331610,
    26'h1000028, 26'h101002C, 26'h102002E, 26'h1030033,
    26'h1040034, 26'h1050034, 26'h1060034, 26'h1070034,
    26'h20003E8, 26'h201000D, 26'h2020008};

  ccl_engine i_ccl_engine (.clk(clk), .arst_n(arst_n), .clkEn(clkEn),
    .hostWrEn(hostWrEn), .hostWrSel(hostWrSel), .hostWrAddr(hostWrAddr),
    .hostWrData(hostWrData), .hostRdSel(hostRdSel),
    .hostRdData(hostRdData), .gateListStart(gateListStart),
    .gateActiveHigh(gateActiveHigh), .gatePin(gatePin),
    .countValue(countValue), .refFreq(refFreq), .refFreqSel(refFreqSel),
    .refCountPulse(refCountPulse), .cntCmd(cntCmd), .holdReg(holdReg),
    .busy(busy));
  ccl_host_model i_ccl_host_model (.clk(clk), .hostWrEn(hostWrEn),
    .hostWrSel(hostWrSel), .hostWrAddr(hostWrAddr),
    .hostWrData(hostWrData), .hostRdSel(hostRdSel),
    .hostRdData(hostRdData));

  always @(posedge clk)
  begin
    // One writer for the seen-command masks; the scenario only asks a clear
    if (sawClr)
    begin
      sawSave <= '0;
      sawReload <= '0;
    end
    else if (busy === 1'b1)
    begin
      sawSave <= sawSave | cntCmd.save;
      sawReload <= sawReload | cntCmd.reload;
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 3000)
    begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 3000)
    begin
      fail_count++;
      end_sim();
    end
  endtask

  // Gate opens for a while, then closes: the close is the trigger
  task automatic run_gate(input logic [7:0] start);
    @(posedge clk);
    gateListStart <= start;
    gatePin <= 1'b1;
    sawClr <= 1'b1;
    @(posedge clk);
    sawClr <= 1'b0;
    repeat (5) @(posedge clk);
    gatePin <= 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
  endtask

  task automatic t_speed();
    run_gate(8'h00);
    cmp(32'(sawSave), 32'h1);
    cmp(32'(sawReload), 32'h1);
    cmp(holdReg[0], 32'd50);
    i_ccl_host_model.rd(3'h1, rv);
    cmp(rv, 32'd20);
  endtask

  // Word after list 3 would save counter 4 if the length ran over
  task automatic t_gear();
    run_gate(8'h08);
    cmp(32'(sawSave), 32'h2);
    cmp(32'(sawReload), 32'h2);
    cmp(holdReg[1], 32'd7);
    i_ccl_host_model.rd(3'h3, rv);
    cmp(rv, 32'd227);
  endtask

  task automatic t_list2();
    run_gate(8'h10);
    cmp(32'(sawSave), 32'h0);
    i_ccl_host_model.rd(3'h2, rv);
    cmp(rv, 32'd20);
    i_ccl_host_model.rd(3'h1, rv);
    cmp(rv, 32'd20);
  endtask

  task automatic t_ref();
    for (int s = 0; s < 8; s++)
    begin
      @(posedge clk);
      refFreqSel <= 3'(s);
      @(posedge clk);
      @(posedge clk);
      #1 cmp(32'(refCountPulse), (s >= 1 && s <= 6) ? 32'(refFreq[s-1]) : 0);
    end
    // Enable low must freeze the registered pulse at its old level
    @(posedge clk);
    clkEn <= 1'b0;
    refFreqSel <= 3'h2;
    repeat (3) @(posedge clk);
    #1 cmp(32'(refCountPulse), 32'h0);
    @(posedge clk);
    clkEn <= 1'b1;
    repeat (2) @(posedge clk);
    #1 cmp(32'(refCountPulse), 32'(refFreq[1]));
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    arst_n = 1'b0;
    clkEn = 1'b1;
    sawClr = 1'b1;
    gateActiveHigh = 1'b1;
    gatePin = 1'b0;
    gateListStart = 8'h00;
    refFreq = 6'h2A;
    refFreqSel = 3'h0;
    countValue = {32'h0000_0011, 32'h0, 32'h0, 32'd7, 32'd50};
    fail_count = 0;
    compares = 0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    foreach (prog[i])
      i_ccl_host_model.wr(prog[i][25:24], prog[i][23:16], 32'(prog[i][15:0]));
    t_speed();
    t_gear();
    t_list2();
    t_ref();
    end_sim();
  end
endmodule
